// >>> rtl/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

    // -------------------------------------------------------------
    // Serial word layout
    // -------------------------------------------------------------
    localparam int          WORD_BITS = 16;     // Bits in one command word
    localparam int          CODE_BITS = 12;     // Bits of DAC data
    localparam int          NUM_DACS  = 4;      // Converter channels
    localparam int          CMD_MSB   = 15;     // Top bit of command nibble
    localparam int          CMD_LSB   = 12;     // Low bit of command nibble
    localparam int          SEL_LSB   = 14;     // Low bit of channel address
    localparam logic [4:0]  FULL_CNT  = 5'h10;  // Bit count of a full word

    // -------------------------------------------------------------
    // Command nibble {address, control}
    // -------------------------------------------------------------
    localparam logic [1:0] CTL_LOAD_IN   = 2'h1; // Load one input register
    localparam logic [1:0] CTL_LOAD_UPD  = 2'h3; // Load one, update all
    localparam logic [3:0] CMD_NOP       = 4'h0; // no_operation_command
    localparam logic [3:0] CMD_UPO_LOW   = 4'h2; // User output low
    localparam logic [3:0] CMD_UPDATE    = 4'h4; // Input to DAC, wake
    localparam logic [3:0] CMD_UPO_HIGH  = 4'h6; // User output high
    localparam logic [3:0] CMD_LOAD_ALL  = 4'h8; // Shift reg to all, wake
    localparam logic [3:0] CMD_MODE0     = 4'ha; // Falling edge out, update
    localparam logic [3:0] CMD_SHUTDOWN  = 4'hc; // Shutdown if unlocked
    localparam logic [3:0] CMD_MODE1     = 4'he; // Rising edge out, update

    // -------------------------------------------------------------
    // Values after reset
    // -------------------------------------------------------------
    localparam logic [11:0] CODE_RESET = 12'h000; // Zero code
    localparam logic        MODE_RESET = 1'b0;    // Falling-edge mode
    localparam logic        UPO_RESET  = 1'b0;    // User output low

    // Power state, one-hot
    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_SHUT = 2'b10
    } power_state_t;

endpackage

// >>> rtl/serial_word_if.sv
`timescale 1ns/10ps
// Word hand-over between the serial front end and the control core
interface serial_word_if;
    logic [15:0] word;       // Last sixteen bits of the frame
    logic        word_valid; // One-cycle pulse at frame end
    logic        rise_mode;  // 1: output on rising edge

    modport shifter (output word, output word_valid, input rise_mode);
    modport core    (input word, input word_valid, output rise_mode);
endinterface

// >>> rtl/serial_shifter.sv
`timescale 1ns/10ps
module serial_shifter
    import dac_ctrl_pkg::*;
(
    input  wire logic      clock_in,   // System clock
    input  wire logic      resetn_in,  // Async reset, active low
    input  wire logic      sclk_in,    // Serial clock pin
    input  wire logic      din_in,     // Serial data pin
    input  wire logic      cs_n_in,    // Chip select pin, active low
    output logic           dout_out,   // Serial data out pin
    serial_word_if.shifter sif         // Words to the core
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic        sclk_m;  // Synchroniser first stages
        logic        din_m;
        logic        cs_m;
        logic        sclk_s;  // Synchronised levels
        logic        din_s;
        logic        cs_s;
        logic        sclk_d;  // Delayed copies for edge finding
        logic        cs_d;
        logic [15:0] sr;      // Shift register
        logic        s16;     // Seventeenth stage, feeds half-cycle lag
        logic        dout;    // Output bit
        logic [4:0]  cnt;     // Bits this frame, saturating
        logic        valid;   // Word pulse
        logic [15:0] word;    // Captured word
    } shift_state_t;

    shift_state_t q_r;
    shift_state_t q_nxt;
    logic         rise;       // Serial clock rising edge
    logic         fall;       // Serial clock falling edge
    logic         cs_rise;    // End of frame

    assign rise    = q_r.sclk_s & ~q_r.sclk_d;
    assign fall    = ~q_r.sclk_s & q_r.sclk_d;
    assign cs_rise = q_r.cs_s & ~q_r.cs_d;

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    // Data and clock pass equal sync depth, so they stay aligned
    always_comb begin
        q_nxt        = q_r;
        q_nxt.sclk_m = sclk_in;
        q_nxt.din_m  = din_in;
        q_nxt.cs_m   = cs_n_in;
        q_nxt.sclk_s = q_r.sclk_m;
        q_nxt.din_s  = q_r.din_m;
        q_nxt.cs_s   = q_r.cs_m;
        q_nxt.sclk_d = q_r.sclk_s;
        q_nxt.cs_d   = q_r.cs_s;
        q_nxt.valid  = 1'b0;
        // Deselected part ignores the shared data line
        if (!q_r.cs_s) begin  // RULE_05
            if (rise) begin
                // Older bits fall out the top toward the next device
                q_nxt.sr  = {q_r.sr[14:0], q_r.din_s};  // RULE_04
                q_nxt.s16 = q_r.sr[15];
                if (sif.rise_mode) begin
                    q_nxt.dout = q_r.sr[15];  // RULE_09
                end
                if (q_r.cnt != FULL_CNT) begin
                    q_nxt.cnt = q_r.cnt + 5'h01;
                end
            end
            if (fall && !sif.rise_mode) begin
                q_nxt.dout = q_r.s16;  // RULE_09
            end
        end
        // Only the latest sixteen bits count, so long chained frames work
        if (cs_rise) begin  // RULE_11 RULE_12
            q_nxt.valid = (q_r.cnt == FULL_CNT);
            q_nxt.word  = q_r.sr;
            q_nxt.cnt   = 5'h00;
        end
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    // Chip select resets high so no false frame end is seen
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q_r      <= '0;
            q_r.cs_m <= 1'b1;
            q_r.cs_s <= 1'b1;
            q_r.cs_d <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign dout_out       = q_r.dout;
    assign sif.word       = q_r.word;
    assign sif.word_valid = q_r.valid;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    sequence s_rise_sel;
        rise && !q_r.cs_s;
    endsequence

    sequence s_fall_sel;
        fall && !q_r.cs_s;
    endsequence

    property p_mode1_lag;
        @(posedge clock_in) disable iff (!resetn_in)
        s_rise_sel and sif.rise_mode |=> dout_out == $past(q_r.sr[15]);
    endproperty
    a_mode1_lag: assert property (p_mode1_lag) // RULE_09
        else $error("rising mode output bit wrong");

    property p_mode0_lag;
        @(posedge clock_in) disable iff (!resetn_in)
        s_fall_sel and !sif.rise_mode |=> dout_out == $past(q_r.s16);
    endproperty
    a_mode0_lag: assert property (p_mode0_lag) // RULE_09
        else $error("falling mode output bit wrong");

    property p_frame_latch;
        @(posedge clock_in) disable iff (!resetn_in)
        cs_rise && q_r.cnt == FULL_CNT
            |=> sif.word_valid && sif.word == $past(q_r.sr);
    endproperty
    a_frame_latch: assert property (p_frame_latch) // RULE_11
        else $error("full frame not handed over");

    property p_deselect_hold;
        @(posedge clock_in) disable iff (!resetn_in)
        q_r.cs_s && !cs_rise |=> $stable(q_r.sr) && $stable(dout_out);
    endproperty
    a_deselect_hold: assert property (p_deselect_hold) // RULE_05
        else $error("shift register moved while deselected");

endmodule

// >>> rtl/dac_lockout_powerup_chain.sv
`timescale 1ns/10ps
// Contract
// (RULE_01) Lockout low blocks software shutdown
// (RULE_02) Lockout falling edge wakes, keeps old outputs
// (RULE_03) Wake needs no serial clock or command
// (RULE_04) Output feeds next device input in chain
// (RULE_05) Shared data line needs separate chip selects
// (RULE_06) Power-up clears input and DAC registers
// (RULE_07) Power-up selects falling-edge output mode
// (RULE_08) Shutdown command works only while unlocked
// (RULE_09) Output lags input 16.5 or 16 clocks
// (RULE_10) No-operation command leaves registers untouched
// (RULE_11) Word takes effect on chip select rise
// (RULE_12) Chained parts share one select, latch together
module dac_lockout_powerup_chain
    import dac_ctrl_pkg::*;
(
    input  wire logic         clock_in,              // System clock
    input  wire logic         resetn_in,             // Power-on reset
    input  wire logic         sclk_in,               // Serial clock
    input  wire logic         din_in,                // Serial data in
    input  wire logic         cs_n_in,               // Chip select
    input  wire logic         shutdown_lockout_n_in, // Lockout, low locks
    output logic              dout_out,              // Serial data out
    output logic              upo_out,               // User logic output
    output logic              shutdown_out,          // Part is shut down
    output logic              rise_mode_out,         // Output edge mode
    output logic [3:0][11:0]  dac_code_out           // DAC registers
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic             lock_m;  // Lockout sync first stage
        logic             lock_s;  // Lockout synchronised
        logic             lock_d;  // Delayed, for falling edge
        power_state_t     state;   // Run or shutdown
        logic             mode;    // 1: rising-edge output
        logic             upo;     // User output level
        logic [3:0][11:0] in_reg;  // Input registers
        logic [3:0][11:0] dac_reg; // DAC registers
    } core_state_t;

    core_state_t   q_r;
    core_state_t   q_nxt;
    serial_word_if sif ();
    logic [3:0]    cmd;        // Command nibble
    logic [1:0]    sel;        // Channel address
    logic [11:0]   data;       // Data field
    logic          wake;       // Lockout falling edge

    assign cmd  = sif.word[CMD_MSB:CMD_LSB];
    assign sel  = sif.word[CMD_MSB:SEL_LSB];
    assign data = sif.word[CODE_BITS-1:0];
    assign wake = ~q_r.lock_s & q_r.lock_d;

    // -------------------------------------------------------------
    // Serial front end
    // -------------------------------------------------------------
    serial_shifter u_shifter (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .sclk_in   (sclk_in),
        .din_in    (din_in),
        .cs_n_in   (cs_n_in),
        .dout_out  (dout_out),
        .sif       (sif.shifter)
    );

    assign sif.rise_mode = q_r.mode;

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        q_nxt        = q_r;
        q_nxt.lock_m = shutdown_lockout_n_in;
        q_nxt.lock_s = q_r.lock_m;
        q_nxt.lock_d = q_r.lock_s;
        // Wake runs on the system clock alone; DAC codes were kept
        if (wake && q_r.state == ST_SHUT) begin  // RULE_02 RULE_03
            q_nxt.state = ST_RUN;
        end
        if (sif.word_valid) begin  // RULE_11
            if (cmd[1:0] == CTL_LOAD_IN) begin
                q_nxt.in_reg[sel] = data;
            end else if (cmd[1:0] == CTL_LOAD_UPD) begin
                q_nxt.in_reg[sel] = data;
                q_nxt.dac_reg     = q_nxt.in_reg;
                q_nxt.state       = ST_RUN;
            end else begin
                case (cmd)
                    CMD_NOP: begin
                        q_nxt.upo = q_r.upo;  // RULE_10
                    end
                    CMD_UPO_LOW: begin
                        q_nxt.upo = 1'b0;
                    end
                    CMD_UPO_HIGH: begin
                        q_nxt.upo = 1'b1;
                    end
                    CMD_UPDATE: begin
                        q_nxt.dac_reg = q_r.in_reg;
                        q_nxt.state   = ST_RUN;
                    end
                    CMD_LOAD_ALL: begin
                        q_nxt.in_reg  = {NUM_DACS{data}};
                        q_nxt.dac_reg = {NUM_DACS{data}};
                        q_nxt.state   = ST_RUN;
                    end
                    CMD_MODE0: begin
                        q_nxt.mode    = 1'b0;
                        q_nxt.dac_reg = q_r.in_reg;
                    end
                    CMD_MODE1: begin
                        q_nxt.mode    = 1'b1;
                        q_nxt.dac_reg = q_r.in_reg;
                    end
                    CMD_SHUTDOWN: begin
                        // Locked part ignores it; a wake in the same
                        // cycle therefore never loses to it
                        if (q_r.lock_s) begin  // RULE_01 RULE_08
                            q_nxt.state = ST_SHUT;
                        end
                    end
                    default: begin
                        q_nxt.upo = q_r.upo;
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    // Lockout assumed released at power-up; sync settles in two edges
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q_r.lock_m  <= 1'b1;
            q_r.lock_s  <= 1'b1;
            q_r.lock_d  <= 1'b1;
            q_r.state   <= ST_RUN;
            q_r.mode    <= MODE_RESET;                 // RULE_07
            q_r.upo     <= UPO_RESET;
            q_r.in_reg  <= {NUM_DACS{CODE_RESET}};     // RULE_06
            q_r.dac_reg <= {NUM_DACS{CODE_RESET}};     // RULE_06
        end else begin
            q_r <= q_nxt;
        end
    end

    assign upo_out       = q_r.upo;
    assign shutdown_out  = (q_r.state == ST_SHUT);
    assign rise_mode_out = q_r.mode;
    assign dac_code_out  = q_r.dac_reg;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    sequence s_cmd(logic [3:0] c);
        sif.word_valid && cmd == c;
    endsequence

    property p_locked_run;
        @(posedge clock_in) disable iff (!resetn_in)
        !q_r.lock_s && !q_r.lock_d |-> !shutdown_out;
    endproperty
    a_locked_run: assert property (p_locked_run) // RULE_01
        else $error("shut down while lockout low");

    property p_wake;
        @(posedge clock_in) disable iff (!resetn_in)
        wake && shutdown_out |=> !shutdown_out && $stable(dac_code_out);
    endproperty
    a_wake: assert property (p_wake) // RULE_02
        else $error("lockout fall did not wake cleanly");

    property p_wake_no_sclk;
        @(posedge clock_in) disable iff (!resetn_in)
        wake && shutdown_out && !sif.word_valid ##1 1 |-> !shutdown_out;
    endproperty
    a_wake_no_sclk: assert property (p_wake_no_sclk) // RULE_03
        else $error("wake waited on serial activity");

    property p_shutdown;
        @(posedge clock_in) disable iff (!resetn_in)
        s_cmd(CMD_SHUTDOWN) ##0 q_r.lock_s |=> shutdown_out;
    endproperty
    a_shutdown: assert property (p_shutdown) // RULE_08
        else $error("shutdown command not taken");

    property p_nop;
        @(posedge clock_in) disable iff (!resetn_in)
        s_cmd(CMD_NOP) |=> $stable(q_r.in_reg) && $stable(dac_code_out)
                           && $stable(upo_out);
    endproperty
    a_nop: assert property (p_nop) // RULE_10
        else $error("no-operation changed a register");

    property p_load_input;
        @(posedge clock_in) disable iff (!resetn_in)
        sif.word_valid && cmd[1:0] == CTL_LOAD_IN
            |=> q_r.in_reg[$past(sel)] == $past(data)
                && $stable(dac_code_out);
    endproperty
    a_load_input: assert property (p_load_input) // RULE_11
        else $error("input register load wrong");

    property p_powerup;
        @(posedge clock_in)
        $rose(resetn_in) |-> dac_code_out == '0 && q_r.in_reg == '0;
    endproperty
    a_powerup: assert property (p_powerup) // RULE_06
        else $error("registers not zero after power-up");

    property p_powerup_mode;
        @(posedge clock_in)
        $rose(resetn_in) |-> !rise_mode_out;
    endproperty
    a_powerup_mode: assert property (p_powerup_mode) // RULE_07
        else $error("output mode not falling edge at power-up");

endmodule

// >>> bench/serial_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Serial master that writes frames and records the echoed data
// ---------------------------------------------------------------
module serial_host_model (
    input  wire logic clock_in,  // System clock
    input  wire logic dout_in,   // Echo from the device
    output logic      sclk_out,  // Serial clock, still between frames
    output logic      din_out,   // Serial data, MSB first
    output logic      cs_n_out   // Dedicated select, active low
);
    logic [31:0] echo_r;         // Echo seen just before each fall

    // Idle lines at time zero
    initial begin
        sclk_out = 1'b0;
        din_out  = 1'b0;
        cs_n_out = 1'b1;
    end

    // One frame of n bits from the low end of bits, MSB first
    task automatic send_frame(input logic [31:0] bits, input int n);
        int i;
        @(posedge clock_in);
        cs_n_out <= 1'b0;
        for (i = 0; i < n; i++) begin
            din_out <= bits[n-1-i];
            repeat (4) @(posedge clock_in);
            sclk_out <= 1'b1;
            repeat (3) @(posedge clock_in);
            // Falling-edge mode only moves after this sample point
            @(negedge clock_in);
            echo_r[i] = dout_in;
            @(posedge clock_in);
            sclk_out <= 1'b0;
        end
        repeat (4) @(posedge clock_in);
        // One select rise latches the whole chain at once
        cs_n_out <= 1'b1;
        din_out  <= ~bits[0];
        repeat (8) @(posedge clock_in);
    endtask

    // Traffic for another part on the shared line; our select stays high
    task automatic clock_deselected(input logic [31:0] bits, input int n);
        int i;
        @(posedge clock_in);
        for (i = 0; i < n; i++) begin
            din_out <= bits[n-1-i];
            repeat (4) @(posedge clock_in);
            sclk_out <= 1'b1;
            repeat (4) @(posedge clock_in);
            sclk_out <= 1'b0;
        end
        repeat (8) @(posedge clock_in);
    endtask
endmodule

// >>> bench/test_dac_lockout_powerup_chain.sv
`timescale 1ns/10ps
module test_dac_lockout_powerup_chain;
    import dac_ctrl_pkg::*;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic             clock_in;   // 10 MHz clock
    logic             resetn_in;  // Power-on reset
    logic             lockout_n;  // Shutdown lockout, low locks
    logic             sclk;       // Serial clock
    logic             din;        // Serial data in
    logic             cs_n;       // Select
    logic             dout;       // Echo
    logic             upo;        // User output
    logic             shut;       // Shutdown flag
    logic             mode;       // Output edge mode
    logic [3:0][11:0] codes;      // DAC registers
    logic [50:0]      snap;       // All visible state
    logic [50:0]      note_q[$];  // Expected state changes, oldest first
    logic             e_shut;     // Expected shutdown
    logic             e_upo;      // Expected user output
    logic             e_mode;     // Expected edge mode
    logic [3:0][11:0] e_code;     // Expected DAC registers
    logic [3:0][11:0] e_in;       // Expected input registers
    logic [11:0]      d;          // Random data
    logic [31:0]      w;          // Chain frame
    int               errors;     // Mismatches
    int               n_tests;    // Comparisons

    assign snap = {shut, upo, mode, codes};

    // Clock
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    // ---------------------------------------------------------------
    // Device and host
    // ---------------------------------------------------------------
    dac_lockout_powerup_chain i_dut (
        .clock_in(clock_in), .resetn_in(resetn_in), .sclk_in(sclk),
        .din_in(din), .cs_n_in(cs_n), .shutdown_lockout_n_in(lockout_n),
        .dout_out(dout), .upo_out(upo), .shutdown_out(shut),
        .rise_mode_out(mode), .dac_code_out(codes)
    );

    serial_host_model i_host (
        .clock_in(clock_in), .dout_in(dout), .sclk_out(sclk),
        .din_out(din), .cs_n_out(cs_n)
    );

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Queue the state that the next visible change must show
    task automatic note();
        note_q.push_back({e_shut, e_upo, e_mode, e_code});
    endtask

    // One 16-bit command word
    task automatic cmd(input logic [3:0] c, input logic [11:0] dd);
        i_host.send_frame({16'h0000, c, dd}, 16);
    endtask

    // 32-bit pass-through frame; last word is a no-operation
    task automatic chain(input int lag);
        int i;
        w = $urandom;
        w[15:12] = CMD_NOP;
        i_host.send_frame(w, 32);
        for (i = lag; i < 32; i++) begin
            check(64'(i_host.echo_r[i]), 64'(w[31-(i-lag)]));
        end
    endtask

    // ---------------------------------------------------------------
    // Monitor: every visible change must match the oldest note
    // ---------------------------------------------------------------
    initial begin
        logic [50:0] prev;
        @(posedge resetn_in);
        #1;
        prev = snap;
        forever begin
            @(posedge clock_in);
            #1;
            if (snap !== prev) begin
                // A change with no note means nothing should have moved
                if (note_q.size() == 0) begin
                    check(64'(snap), 64'(prev));
                end else begin
                    check(64'(snap), 64'(note_q.pop_front()));
                end
                prev = snap;
            end
        end
    end

    // Watchdog, several times the expected run
    initial begin
        repeat (30000) @(posedge clock_in);
        errors++;
        end_of_test();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        resetn_in = 1'b0;
        lockout_n = 1'b1;
        errors    = 0;
        n_tests   = 0;
        {e_shut, e_upo, e_mode, e_code, e_in} = '0;
        void'($urandom(32'hc867c270));
        repeat (10) @(posedge clock_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        check(64'(codes), 64'h0);
        check(64'(mode), 64'(MODE_RESET));
        // Input registers only: nothing visible may move
        for (int i = 0; i < 4; i++) begin
            e_in[i] = 12'($urandom);
            cmd({i[1:0], CTL_LOAD_IN}, e_in[i]);
        end
        e_code = e_in;
        note();
        cmd(CMD_UPDATE, 12'($urandom));
        // Load one and update all, every channel
        for (int i = 0; i < 4; i++) begin
            // Forced to differ so that every load shows a visible change
            d = e_in[i] ^ (12'($urandom) | 12'h001);
            e_in[i] = d;
            e_code = e_in;
            note();
            cmd({i[1:0], CTL_LOAD_UPD}, d);
        end
        d = 12'($urandom);
        e_in = {4{d}};
        e_code = e_in;
        note();
        cmd(CMD_LOAD_ALL, d);
        e_upo = 1'b1;
        note();
        cmd(CMD_UPO_HIGH, 12'($urandom));
        e_upo = 1'b0;
        note();
        cmd(CMD_UPO_LOW, 12'($urandom));
        cmd(CMD_NOP, 12'($urandom));
        // Foreign traffic on the shared line must leave no trace; a part
        // that counted it would take the short frame below as a command
        i_host.clock_deselected(32'h0000_6666, 16);
        // Short frame must be dropped
        i_host.send_frame({20'h0, CMD_UPO_HIGH, 8'hff}, 12);
        // Shutdown, then wake by lockout with the serial clock still
        e_shut = 1'b1;
        note();
        cmd(CMD_SHUTDOWN, 12'($urandom));
        e_shut = 1'b0;
        note();
        @(posedge clock_in);
        lockout_n <= 1'b0;
        repeat (10) @(posedge clock_in);
        cmd(CMD_SHUTDOWN, 12'($urandom));
        lockout_n <= 1'b1;
        repeat (10) @(posedge clock_in);
        e_shut = 1'b1;
        note();
        cmd(CMD_SHUTDOWN, 12'($urandom));
        e_shut = 1'b0;
        note();
        cmd(CMD_UPDATE, 12'($urandom));
        // Edge modes and chain pass-through; mode words also update DACs
        e_in[0] = ~e_in[0];
        cmd({2'h0, CTL_LOAD_IN}, e_in[0]);
        e_code = e_in;
        e_mode = 1'b1;
        note();
        cmd(CMD_MODE1, 12'($urandom));
        chain(16);
        e_in[1] = ~e_in[1];
        cmd({2'h1, CTL_LOAD_IN}, e_in[1]);
        e_code = e_in;
        e_mode = 1'b0;
        note();
        cmd(CMD_MODE0, 12'($urandom));
        chain(17);
        // Reset in mid-run clears everything again
        {e_shut, e_upo, e_mode, e_code} = '0;
        note();
        @(posedge clock_in);
        resetn_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        check(64'(snap), 64'h0);
        check(64'(note_q.size()), 64'h0);
        end_of_test();
    end
endmodule
